// File: logic/pbsp_port.sv
// Purpose: Pipelined burst SRAM port with common data I/O
// Assumes: Synchronous pins sampled at the clock rise; output enable
//   and burst strap are asynchronous levels
// Notes: Plain pins, no register bus
// Function
// RQ1: Strap low linear, high or open interleaved
// RQ2: System keeps strap constant while operating
// RQ3: Inputs and data outputs registered on rising edge
// RQ4: Either strobe starts; processor strobe needs select
// RQ5: Counter loads two low address bits at start
// RQ6: Read starts: strobe, selected, no write enables
// RQ7: Read data appears after next edge under enable
// RQ8: First cycle out of deselect stays high impedance
// RQ9: Deselect floats outputs at once; back-to-back reads
// RQ10: Processor start ignores write controls and advance
// RQ11: Processor write: controls at second edge decide
// RQ12: Global write stores all four bytes
// RQ13: Byte write changes selected bytes only
// RQ14: Any write cycle floats data and parity
// RQ15: Host raises output enable before driving data; t_proc_write drives its write data with output enable low
// RQ16: Controller write completes in one clock
// RQ17: Advance low steps the burst counter
// RQ18: Interleaved beat equals start xor beat index
// RQ19: Both strobes low: processor strobe wins
// RQ20: Linear beat equals start plus beat index
`timescale 1ns/1ns
`include "pbsp_params.svh"
module pbsp_port (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`PBSP_ADDR_W-1:0] addr_i,
  input wire logic [`PBSP_DATA_W-1:0] dq_i,
  input wire logic [`PBSP_PAR_W-1:0] parity_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic [`PBSP_BYTES-1:0] byte_select_n_i,
  input wire logic chip_sel_a_n_i,
  input wire logic chip_sel_b_i,
  input wire logic chip_sel_c_n_i,
  input wire logic out_enable_n_i,
  input wire logic burst_mode_i,
  output logic [`PBSP_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic [`PBSP_PAR_W-1:0] parity_o,
  output logic parity_oe_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`PBSP_WORD_W-1:0] mem_q [0:`PBSP_DEPTH-1];
  pbsp_pkg::pbsp_state_type state_q, state_d;
  logic [`PBSP_HI_W-1:0] addr_hi_q, addr_hi_d;
  logic [`PBSP_ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic rd_pend_q, rd_pend_d;
  logic [`PBSP_WORD_W-1:0] dout_q, dout_d;
  logic valid_d, drv_q, drv_d;
  logic oe_n_s, mode_s;
  logic sel_all, proc_seen, ctrl_seen, any_strobe;
  logic start, desel_now, cont;
  logic wr_req, wr_now, rd_now, step;
  logic [`PBSP_BYTES-1:0] wr_bytes;
  logic [`PBSP_ADDR_W-1:0] waddr;
  logic [`PBSP_WORD_W-1:0] wr_word, cur_word;
  logic [`PBSP_CNT_W-1:0] cnt_cur, cnt_nxt;

  // ----------------------------------------------------------------
  // Asynchronous levels
  // ----------------------------------------------------------------
  // Unconnected strap reads high through the pin pull-up
  pbsp_sync2 #(.W(1), .RST(`PBSP_RST_MODE)) u_mode_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(burst_mode_i),
    .q_o(mode_s)
  );

  // Enable is asynchronous; two flops cost up to two cycles of lag
  pbsp_sync2 #(.W(1), .RST(`PBSP_RST_OE_N)) u_oe_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(out_enable_n_i),
    .q_o(oe_n_s)
  );

  pbsp_burst_ctr u_ctr (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(start),
    .load_val_i(addr_i[`PBSP_CNT_W-1:0]),
    .step_i(step),
    .interleave_i(mode_s), // RQ1
    .cur_o(cnt_cur),
    .nxt_o(cnt_nxt)
  );

  // ----------------------------------------------------------------
  // Cycle decode at the clock rise
  // ----------------------------------------------------------------
  always_comb begin
    sel_all = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
    proc_seen = !proc_addr_strobe_n_i && !chip_sel_a_n_i; // RQ4
    ctrl_seen = !ctrl_addr_strobe_n_i && !proc_seen; // RQ19
    any_strobe = proc_seen || ctrl_seen;
    start = any_strobe && sel_all; // RQ4
    desel_now = any_strobe && !sel_all;
    cont = !any_strobe && (state_q != pbsp_pkg::st_desel);
    wr_req = !global_write_n_i ||
             (!byte_write_enable_n_i && !(&byte_select_n_i));
    // Processor start never writes: controls ignored that cycle
    wr_now = (ctrl_seen && start && wr_req) || (cont && wr_req); // RQ10 RQ16
    rd_now = (start || cont) && !wr_now; // RQ6
    step = cont && !burst_advance_n_i; // RQ17
    if (!global_write_n_i) begin
      wr_bytes = {`PBSP_BYTES{1'b1}}; // RQ12
    end else if (!byte_write_enable_n_i) begin
      wr_bytes = ~byte_select_n_i; // RQ13
    end else begin
      wr_bytes = {`PBSP_BYTES{1'b0}};
    end
    if (start) begin
      waddr = addr_i; // RQ5
    end else begin
      waddr = {addr_hi_q, step ? cnt_nxt : cnt_cur}; // RQ17
    end
    cur_word = mem_q[waddr];
    wr_word = {parity_i, dq_i};
  end

  // ----------------------------------------------------------------
  // Access state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_hi_d = addr_hi_q;
    if (start) begin
      addr_hi_d = addr_i[`PBSP_ADDR_W-1:`PBSP_CNT_W];
    end
    case (state_q)
      pbsp_pkg::st_desel,
      pbsp_pkg::st_read,
      pbsp_pkg::st_write: begin
        if (desel_now) begin
          state_d = pbsp_pkg::st_desel; // RQ9
        end else if (wr_now) begin
          state_d = pbsp_pkg::st_write; // RQ11
        end else if (rd_now) begin
          state_d = pbsp_pkg::st_read;
        end
      end
      default: begin
        state_d = pbsp_pkg::st_desel;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q <= pbsp_pkg::st_desel;
      addr_hi_q <= `PBSP_RST_HI;
    end else begin
      state_q <= state_d;
      addr_hi_q <= addr_hi_d;
    end
  end

  // ----------------------------------------------------------------
  // Core array
  // ----------------------------------------------------------------
  // Self-timed write modelled as a store at the sampling edge
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < `PBSP_BYTES; b++) begin
      if (resetn_i && wr_now && wr_bytes[b]) begin
        mem_q[waddr][b*8 +: 8] <= wr_word[b*8 +: 8]; // RQ13
        mem_q[waddr][`PBSP_DATA_W+b] <= wr_word[`PBSP_DATA_W+b];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read pipeline and output drive
  // ----------------------------------------------------------------
  always_comb begin
    rd_addr_d = rd_now ? waddr : rd_addr_q; // RQ7
    rd_pend_d = rd_now;
    dout_d = rd_pend_q ? mem_q[rd_addr_q] : dout_q; // RQ3
    // Only a read registered one edge earlier may drive; this keeps
    // the first cycle out of deselect floating
    valid_d = rd_pend_q && !wr_now && !desel_now; // RQ8 RQ9 RQ14
    drv_d = valid_d && !oe_n_s; // RQ7
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_addr_q <= `PBSP_RST_ADDR;
      rd_pend_q <= 1'b0;
      dout_q <= `PBSP_RST_WORD;
      drv_q <= 1'b0;
    end else begin
      rd_addr_q <= rd_addr_d;
      rd_pend_q <= rd_pend_d;
      dout_q <= dout_d; // RQ3
      drv_q <= drv_d;
    end
  end

  assign dq_o = dout_q[`PBSP_DATA_W-1:0];
  assign parity_o = dout_q[`PBSP_WORD_W-1:`PBSP_DATA_W];
  assign dq_oe_o = drv_q;
  assign parity_oe_o = drv_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wr_float;
    @(posedge clk_i) disable iff (!resetn_i)
      wr_now |=> !dq_oe_o && !parity_oe_o;
  endproperty
  a_wr_float: assert property (p_wr_float) // RQ14
    else $error("Data pins driven after a write cycle");

  property p_desel_float;
    @(posedge clk_i) disable iff (!resetn_i)
      desel_now |=> !dq_oe_o;
  endproperty
  a_desel_float: assert property (p_desel_float) // RQ9
    else $error("Outputs not floated after deselect");

  property p_first_float;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q == pbsp_pkg::st_desel) && start |=> !dq_oe_o;
  endproperty
  a_first_float: assert property (p_first_float) // RQ8
    else $error("Outputs driven in first cycle out of deselect");

  property p_read_drive;
    @(posedge clk_i) disable iff (!resetn_i)
      rd_now && !oe_n_s ##1 (!wr_now && !desel_now && !oe_n_s)
      |=> dq_oe_o && (dq_o == $past(mem_q[rd_addr_q][31:0]));
  endproperty
  a_read_drive: assert property (p_read_drive) // RQ7
    else $error("Read data not driven after next edge");

  property p_global_wr;
    @(posedge clk_i) disable iff (!resetn_i)
      wr_now && !global_write_n_i |=> mem_q[$past(waddr)] == $past(wr_word);
  endproperty
  a_global_wr: assert property (p_global_wr) // RQ12
    else $error("Global write did not store all bytes");

  property p_byte_keep;
    @(posedge clk_i) disable iff (!resetn_i)
      wr_now && global_write_n_i && byte_select_n_i[0]
      |=> mem_q[$past(waddr)][7:0] == $past(cur_word[7:0]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) // RQ13
    else $error("Unselected byte changed by byte write");

  property p_proc_no_wr;
    @(posedge clk_i) disable iff (!resetn_i)
      proc_seen && sel_all |-> !wr_now ##1 (state_q == pbsp_pkg::st_read);
  endproperty
  a_proc_no_wr: assert property (p_proc_no_wr) // RQ10
    else $error("Processor start acted on write controls");

  property p_both_strobes;
    @(posedge clk_i) disable iff (!resetn_i)
      !proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && sel_all && wr_req
      |=> state_q == pbsp_pkg::st_read;
  endproperty
  a_both_strobes: assert property (p_both_strobes) // RQ19
    else $error("Controller strobe honoured beside processor strobe");

  property p_ctrl_wr;
    @(posedge clk_i) disable iff (!resetn_i)
      !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && sel_all && wr_req
      |-> wr_now && (waddr == addr_i);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) // RQ16
    else $error("Controller write not done in one clock");

  property p_ctrl_rd;
    @(posedge clk_i) disable iff (!resetn_i)
      !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && sel_all && !wr_req
      |=> state_q == pbsp_pkg::st_read && rd_pend_q;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) // RQ6
    else $error("Read not started by controller strobe");

  property p_proc_gate;
    @(posedge clk_i) disable iff (!resetn_i)
      chip_sel_a_n_i && ctrl_addr_strobe_n_i &&
      (state_q == pbsp_pkg::st_desel) |=> state_q == pbsp_pkg::st_desel;
  endproperty
  a_proc_gate: assert property (p_proc_gate) // RQ4
    else $error("Processor strobe honoured with first select high");

  property p_load;
    @(posedge clk_i) disable iff (!resetn_i)
      start |=> cnt_cur == $past(addr_i[1:0]);
  endproperty
  a_load: assert property (p_load) // RQ5
    else $error("Burst counter did not load low address bits");

  property p_linear;
    @(posedge clk_i) disable iff (!resetn_i)
      step && !mode_s && $stable(mode_s) |=> cnt_cur == $past(cnt_cur) + 2'h1;
  endproperty
  a_linear: assert property (p_linear) // RQ20
    else $error("Linear burst step wrong");

  property p_inter;
    @(posedge clk_i) disable iff (!resetn_i)
      start ##1 (step && mode_s && $stable(mode_s))
      |=> cnt_cur == ($past(cnt_cur) ^ 2'h1);
  endproperty
  a_inter: assert property (p_inter) // RQ18
    else $error("Interleaved burst step wrong");

  c_read: cover property (@(posedge clk_i) disable iff (!resetn_i)
    rd_now ##2 dq_oe_o);
  c_burst: cover property (@(posedge clk_i) disable iff (!resetn_i)
    start ##1 step ##1 step ##1 step);
  c_proc_wr: cover property (@(posedge clk_i) disable iff (!resetn_i)
    proc_seen && sel_all ##1 wr_now);

endmodule // pbsp_port

// File: shared/pbsp_params.svh
// Purpose: Widths, sizes and reset values of the burst SRAM port
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef PBSP_PARAMS_SVH
`define PBSP_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------
`define PBSP_ADDR_W 17
`define PBSP_HI_W 15
`define PBSP_CNT_W 2
`define PBSP_DATA_W 32
`define PBSP_PAR_W 4
`define PBSP_BYTES 4
`define PBSP_WORD_W 36
`define PBSP_DEPTH 131072

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PBSP_RST_MODE 1'h1
`define PBSP_RST_OE_N 1'h1
`define PBSP_RST_WORD 36'h0_0000_0000
`define PBSP_RST_HI 15'h0000
`define PBSP_RST_ADDR 17'h0_0000
`define PBSP_RST_CNT 2'h0

`endif

// File: shared/pbsp_pkg.sv
// Purpose: Types shared by the burst SRAM port
// Assumes: Nothing
// Notes: Constants live in pbsp_params.svh
package pbsp_pkg;

  // ----------------------------------------------------------------
  // Access phase
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_desel,
    st_read,
    st_write
  } pbsp_state_type;

endpackage

// File: logic/pbsp_sync2.sv
// Purpose: Two flop synchroniser for asynchronous levels
// Assumes: Synchronous active low reset
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module pbsp_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule // pbsp_sync2

// File: logic/pbsp_burst_ctr.sv
// Purpose: Two bit wraparound burst address counter
// Assumes: Load and step never in the same cycle
// Notes: Keeps start bits and beat index; order chosen by strap
`timescale 1ns/1ns
`include "pbsp_params.svh"
module pbsp_burst_ctr (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [`PBSP_CNT_W-1:0] load_val_i,
  input wire logic step_i,
  input wire logic interleave_i,
  output logic [`PBSP_CNT_W-1:0] cur_o,
  output logic [`PBSP_CNT_W-1:0] nxt_o
);

  logic [`PBSP_CNT_W-1:0] start_q;
  logic [`PBSP_CNT_W-1:0] start_d;
  logic [`PBSP_CNT_W-1:0] beat_q;
  logic [`PBSP_CNT_W-1:0] beat_d;
  logic [`PBSP_CNT_W-1:0] beat_nxt;

  // ----------------------------------------------------------------
  // Address order
  // ----------------------------------------------------------------
  always_comb begin
    beat_nxt = beat_q + 2'h1;
    if (interleave_i) begin
      cur_o = start_q ^ beat_q; // RQ18
      nxt_o = start_q ^ beat_nxt; // RQ18
    end else begin
      cur_o = start_q + beat_q; // RQ20
      nxt_o = start_q + beat_nxt; // RQ20
    end
    start_d = start_q;
    beat_d = beat_q;
    if (load_i) begin
      start_d = load_val_i; // RQ5
      beat_d = `PBSP_RST_CNT;
    end else if (step_i) begin
      beat_d = beat_nxt; // RQ17
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      start_q <= `PBSP_RST_CNT;
      beat_q <= `PBSP_RST_CNT;
    end else begin
      start_q <= start_d;
      beat_q <= beat_d;
    end
  end

endmodule // pbsp_burst_ctr

// File: verification/pbsp_host.sv
// Purpose: Host model that drives the burst SRAM port pins
// Assumes: Pins change just after the falling clock edge
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/1ns
`include "pbsp_params.svh"
module pbsp_host (
  input wire logic clk_i,
  input wire logic [`PBSP_DATA_W-1:0] dev_dq_i,
  input wire logic dev_oe_i,
  input wire logic [`PBSP_PAR_W-1:0] dev_parity_i,
  output logic [`PBSP_ADDR_W-1:0] addr_o,
  output logic [`PBSP_DATA_W-1:0] bus_dq_o,
  output logic [`PBSP_PAR_W-1:0] bus_parity_o,
  output logic proc_addr_strobe_n_o,
  output logic ctrl_addr_strobe_n_o,
  output logic burst_advance_n_o,
  output logic global_write_n_o,
  output logic byte_write_enable_n_o,
  output logic [`PBSP_BYTES-1:0] byte_select_n_o,
  output logic chip_sel_a_n_o,
  output logic chip_sel_b_o,
  output logic chip_sel_c_n_o,
  output logic out_enable_n_o,
  output logic burst_mode_o
);
  logic [7:0] c_q = 8'hb8;
  logic [16:0] a_q = 17'h0_0000;
  logic [35:0] w_q = 36'h0_0000_0000;
  logic [3:0] b_q = 4'hf;
  logic drv_q = 1'h0;
  logic oe_q = 1'h1;
  logic mode_q = 1'h1;

  assign {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, burst_advance_n_o,
    global_write_n_o, byte_write_enable_n_o, chip_sel_a_n_o, chip_sel_b_o,
    chip_sel_c_n_o} = c_q;
  assign addr_o = a_q;
  assign byte_select_n_o = b_q;
  assign out_enable_n_o = oe_q;
  assign burst_mode_o = mode_q;
  // Flipped when released, so a stale word never reads as valid
  assign {bus_parity_o, bus_dq_o} = dev_oe_i ? {dev_parity_i, dev_dq_i} :
    drv_q ? w_q : ~w_q;

  // Wr 1 drives data politely, 2 drives it without raising output enable
  task automatic pin(input logic [7:0] c, input logic [16:0] a,
    input logic [35:0] w, input logic [3:0] b, input logic [1:0] wr);
    @(negedge clk_i);
    c_q = c;
    a_q = a;
    w_q = w;
    b_q = b;
    drv_q = |wr;
    if (wr == 2'h1) begin
      oe_q = 1'h1;
    end
    @(posedge clk_i);
    #1;
  endtask

  // Strap is only moved while the port sits in reset
  task automatic lvl(input logic oe, input logic md);
    @(negedge clk_i);
    oe_q = oe;
    mode_q = md;
  endtask
endmodule // pbsp_host

// File: verification/pbsp_port_tb.sv
// Purpose: Self-checking bench for the burst SRAM port
// Assumes: Host model owns every pin but clock and reset
// Notes: Words live at 0x100 to 0x103
`timescale 1ns/1ns
`include "pbsp_params.svh"
module pbsp_port_tb;
  localparam logic [7:0] DES = 8'hb8;
  localparam logic [7:0] CRD = 8'hba;
  localparam logic [7:0] CGW = 8'ha2;
  localparam logic [7:0] CBW = 8'hb2;
  localparam logic [7:0] PST = 8'h42;
  localparam logic [7:0] GWR = 8'hea;
  localparam logic [7:0] RDN = 8'hda;
  localparam logic [7:0] SUS = 8'hfa;
  localparam logic [7:0] BOTH = 8'h2a;
  localparam logic [7:0] PIG = 8'h7e;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  int bad_count = 0;
  int checks_done = 0;
  logic [35:0] m [4];
  wire logic [16:0] ad;
  wire logic [31:0] dqi, dqo;
  wire logic [3:0] pri, pro, bs;
  wire logic ps, cs, burst_advance_n, gw, byte_write_enable_n, sa, sb, sc, oe, md, dqe, pre;

  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  pbsp_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(ad),
    .dq_i(dqi), .parity_i(pri), .proc_addr_strobe_n_i(ps),
    .ctrl_addr_strobe_n_i(cs), .burst_advance_n_i(burst_advance_n),
    .global_write_n_i(gw), .byte_write_enable_n_i(byte_write_enable_n),
    .byte_select_n_i(bs), .chip_sel_a_n_i(sa), .chip_sel_b_i(sb),
    .chip_sel_c_n_i(sc), .out_enable_n_i(oe), .burst_mode_i(md),
    .dq_o(dqo), .dq_oe_o(dqe), .parity_o(pro), .parity_oe_o(pre));
  pbsp_host host (.clk_i(clk_i), .dev_dq_i(dqo), .dev_oe_i(dqe),
    .dev_parity_i(pro), .addr_o(ad), .bus_dq_o(dqi), .bus_parity_o(pri),
    .proc_addr_strobe_n_o(ps), .ctrl_addr_strobe_n_o(cs),
    .burst_advance_n_o(burst_advance_n), .global_write_n_o(gw),
    .byte_write_enable_n_o(byte_write_enable_n), .byte_select_n_o(bs),
    .chip_sel_a_n_o(sa), .chip_sel_b_o(sb), .chip_sel_c_n_o(sc),
    .out_enable_n_o(oe), .burst_mode_o(md));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [35:0] e);
    chk({dqe, pro, dqo}, {1'h1, e});
  endtask

  task automatic off();
    chk({35'h0, pre, dqe}, 37'h0);
  endtask

  task automatic go(input logic [7:0] c, input logic [16:0] a);
    host.pin(c, a, 36'h0_0000_0000, 4'hf, 2'h0);
  endtask

  task automatic do_reset(input logic mode);
    host.lvl(1'h1, mode);
    resetn_i = 1'h0;
    repeat (12) @(negedge clk_i);
    resetn_i = 1'h1;
    repeat (3) go(DES, 17'h0_0000);
    off();
  endtask

  task automatic wr(input logic [7:0] c, input logic [1:0] i,
    input logic [35:0] w, input logic [3:0] b);
    host.pin(c, {15'h0040, i}, w, b, 2'h1);
    off();
    for (int k = 0; k < 4; k++) begin
      if (c == CGW || !b[k]) begin
        m[i][8*k +: 8] = w[8*k +: 8];
        m[i][32+k] = w[32+k];
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_writes();
    for (int i = 0; i < 4; i++) begin
      wr(CGW, i[1:0], {i[3:0], {8{i[3:0] + 4'h1}}}, 4'hf);
    end
    wr(CBW, 2'h0, 36'h5_a5a5_a5a5, 4'h5);
  endtask

  task automatic t_burst(input logic ilv, input logic [1:0] s);
    logic [1:0] k;
    repeat (3) go(DES, 17'h0_0000);
    off();
    go(CRD, {15'h0040, s});
    off();
    for (int j = 0; j < 4; j++) begin
      go(j < 3 ? RDN : SUS, 17'h0_0000);
      k = ilv ? s ^ j[1:0] : s + j[1:0];
      rd(m[k]);
    end
  endtask

  task automatic t_ignore();
    go(PIG, 17'h0_0000);
    rd(m[2]);
    go(DES, 17'h0_0000);
    off();
    go(PIG, 17'h0_0000);
    off();
  endtask

  task automatic t_b2b();
    go(CRD, 17'h0_0102);
    off();
    go(CRD, 17'h0_0103);
    rd(m[2]);
    go(BOTH, 17'h0_0101);
    rd(m[3]);
    go(SUS, 17'h0_0000);
    rd(m[1]);
  endtask

  task automatic t_proc_write();
    // Float the port first so the write data meets no read drive
    go(DES, 17'h0_0000);
    go(PST, 17'h0_0103);
    host.pin(GWR, 17'h0_0000, 36'hc_3c3c_3c3c, 4'hf, 2'h2);
    off();
    m[3] = 36'hc_3c3c_3c3c;
    go(DES, 17'h0_0000);
    go(CRD, 17'h0_0103);
    go(SUS, 17'h0_0000);
    rd(m[3]);
  endtask

  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(1'h1);
    t_writes();
    host.lvl(1'h0, 1'h1);
    t_burst(1'h1, 2'h1);
    t_ignore();
    t_b2b();
    t_proc_write();
    do_reset(1'h0);
    host.lvl(1'h0, 1'h0);
    t_burst(1'h0, 2'h2);
    results();
  end

  initial begin
    repeat (2000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule // pbsp_port_tb
